// ==== inc/bvs_pkg.sv ====
// constants, field layout and timing for the buck scaling control block
// assumes a 100 MHz pclk and an APB slave with 32-bit data
package bvs_pkg;
    // ======================================================================
    // register map (printed offsets are indices, byte address is index times four)
    localparam logic [15:0] BVS_IDX_SCALE  = 16'h405A;
    localparam logic [15:0] BVS_IDX_BUCK2  = 16'h405B;
    localparam logic [17:0] BVS_ADDR_SCALE = {BVS_IDX_SCALE, 2'b00};
    localparam logic [17:0] BVS_ADDR_BUCK2 = {BVS_IDX_BUCK2, 2'b00};
    localparam logic [17:0] BVS_ADDR_STAT  = 18'h16180;
    // ======================================================================
    // field positions
    localparam int BVS_SRC_LSB   = 11;
    localparam int BVS_VSEL_LSB  = 0;
    localparam int BVS_RATE_LSB  = 14;
    localparam int BVS_PHASE_BIT = 12;
    localparam int BVS_FREQ_LSB  = 8;
    localparam int BVS_FLT_BIT   = 7;
    localparam int BVS_SS_LSB    = 4;
    localparam int BVS_CAP_LSB   = 0;
    // ======================================================================
    // reset values
    localparam logic [1:0] BVS_SRC_RST   = 2'h0;
    localparam logic [6:0] BVS_VSEL_RST  = 7'h00;
    localparam logic [1:0] BVS_RATE_RST  = 2'h2;
    localparam logic       BVS_PHASE_RST = 1'b1;
    localparam logic [1:0] BVS_FREQ_RST  = 2'h0;
    localparam logic       BVS_FLT_RST   = 1'b0;
    localparam logic [1:0] BVS_SS_RST    = 2'h0;
    localparam logic [1:0] BVS_CAP_RST   = 2'h0;
    // ======================================================================
    // code limits
    localparam logic [6:0] BVS_VSEL_MIN  = 7'h08;
    localparam logic [6:0] BVS_VSEL_MAX  = 7'h68;
    localparam logic [6:0] BVS_VSEL_4MHZ = 7'h48;
    localparam logic [1:0] BVS_FREQ_4MHZ = 2'h2;
    localparam logic [1:0] BVS_CAP_OK    = 2'h2;
    localparam int         BVS_SS_STEPS  = 8;
    // ======================================================================
    // timing: microseconds and cycles at 100 MHz
    localparam int BVS_CLK_MHZ   = 100;
    localparam int BVS_RAMP_US   = 8;
    localparam int BVS_SS_US     = 32;
    localparam int BVS_RAMP_CYC  = BVS_RAMP_US * BVS_CLK_MHZ;
    localparam int BVS_SS_CYC    = BVS_SS_US * BVS_CLK_MHZ;
    localparam int BVS_TW        = 15;

    typedef enum logic [1:0] {
        BVS_SRC_OFF = 2'b00,
        BVS_SRC_SW  = 2'b01,
        BVS_SRC_HW1 = 2'b10,
        BVS_SRC_HW2 = 2'b11
    } bvs_src_t;

    typedef enum logic [1:0] {
        BVS_SS_IDLE = 2'b00,
        BVS_SS_RUN  = 2'b01,
        BVS_SS_DONE = 2'b10
    } bvs_ss_state_t;
endpackage

// ==== logic/bvs_tick.sv ====
// interval timer: pulses once every base interval times 2^shift
// assumes same clock and enable as its parent
`timescale 1ns/1ns
module bvs_tick (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic [14:0] base_cyc,
    input  wire logic [1:0]  shift,
    output logic             tick
);
    typedef struct packed {
        logic [17:0] cnt;
        logic        tick;
    } bvs_tick_st_t;
    bvs_tick_st_t s_q;
    bvs_tick_st_t s_d;
    logic [17:0]  limit;

    // count to the scaled limit then wrap
    always_comb begin
        limit  = ({3'b000, base_cyc} << shift) - 18'h00001;
        s_d    = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 18'h00000;
        end else if (s_q.cnt >= limit) begin
            s_d.cnt  = 18'h00000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 18'h00001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// ==== logic/bvs_ctrl.sv ====
// buck1 scaling and buck2 control registers behind an APB slave
// assumes pclk 100 MHz; hardware scaling inputs and start requests are asynchronous pins
`timescale 1ns/1ns
module bvs_ctrl (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [17:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    input  wire logic                cfg_load,
    input  wire logic [1:0]          cfg_freq,
    input  wire logic [1:0]          cfg_cap,
    input  wire logic                hw_scaling_input_one,
    input  wire logic                hw_scaling_input_two,
    input  wire logic                buck2_enable,
    output logic                     buck1_scaling_active,
    output logic [6:0]               buck1_target_code,
    output logic                     buck2_ramp_tick,
    output logic                     buck2_clock_phase,
    output logic [1:0]               buck2_switch_frequency,
    output logic                     buck2_discharge,
    output logic [2:0]               buck2_softstart_level,
    output logic                     buck2_softstart_done,
    output logic                     buck2_config_valid
);
    import bvs_pkg::*;

    typedef struct packed {
        logic [1:0]    hw1_sync;
        logic [1:0]    hw2_sync;
        logic [1:0]    en_sync;
        logic [1:0]    src;
        logic [6:0]    vsel;
        logic [1:0]    rate;
        logic          phase;
        logic [1:0]    freq;
        logic          flt;
        logic [1:0]    ss;
        logic [1:0]    cap;
        logic          active;
        logic [6:0]    target;
        bvs_ss_state_t ss_st;
        logic [2:0]    ss_lvl;
        logic          ss_done;
        logic          ramp_tick;
        logic          discharge;
        logic          valid;
        logic          ready;
        logic          err;
        logic [31:0]   rdata;
    } bvs_st_t;

    bvs_st_t s_q;
    bvs_st_t s_d;
    logic    ramp_pulse;
    logic    ss_pulse;
    logic    wr_acc;
    logic    rd_acc;
    logic [6:0] clamped;

    // ======================================================================
    // step timers
    bvs_tick u_ramp (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .run      (s_q.rate != 2'h3),
        .base_cyc (15'(BVS_RAMP_CYC)),
        .shift    (2'(2'h2 - s_q.rate)),   // 00->32us, 01->16us, 10->8us
        .tick     (ramp_pulse)
    );

    bvs_tick u_ss (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .run      (s_q.ss_st == BVS_SS_RUN),
        .base_cyc (15'(BVS_SS_CYC)),
        .shift    (s_q.ss),                // 32/64/128/256 us per step
        .tick     (ss_pulse)
    );

    // ======================================================================
    // next state
    always_comb begin
        s_d           = s_q;
        wr_acc        = psel && penable && pwrite && s_q.ready;  // lands at the pready edge
        rd_acc        = psel && !penable;
        s_d.ready     = psel && !penable;
        s_d.hw1_sync  = {s_q.hw1_sync[0], hw_scaling_input_one};
        s_d.hw2_sync  = {s_q.hw2_sync[0], hw_scaling_input_two};
        s_d.en_sync   = {s_q.en_sync[0], buck2_enable};
        s_d.ramp_tick = 1'b0;
        s_d.err       = 1'b0;                                    // error stands with pready only

        // bus slave: no wait states, pready in the first access cycle, unmapped addresses return error
        if (rd_acc) begin
            s_d.err   = 1'b0;
            s_d.rdata = 32'h0000_0000;
            case (paddr)
                BVS_ADDR_SCALE: begin
                    s_d.rdata[BVS_SRC_LSB +: 2]  = s_q.src;
                    s_d.rdata[BVS_VSEL_LSB +: 7] = s_q.vsel;
                end
                BVS_ADDR_BUCK2: begin
                    s_d.rdata[BVS_RATE_LSB +: 2] = s_q.rate;
                    s_d.rdata[BVS_PHASE_BIT]     = s_q.phase;
                    s_d.rdata[BVS_FREQ_LSB +: 2] = s_q.freq;
                    s_d.rdata[BVS_FLT_BIT]       = s_q.flt;
                    s_d.rdata[BVS_SS_LSB +: 2]   = s_q.ss;
                    s_d.rdata[BVS_CAP_LSB +: 2]  = s_q.cap;
                end
                BVS_ADDR_STAT: begin
                    s_d.rdata[0]   = s_q.active;
                    s_d.rdata[1]   = s_q.valid;
                    s_d.rdata[2]   = s_q.ss_st == BVS_SS_DONE;
                    s_d.rdata[6:4] = s_q.ss_lvl;
                    s_d.rdata[14:8] = s_q.target;
                end
                default: s_d.err = 1'b1;
            endcase
        end

        // register writes, byte lanes honoured
        if (wr_acc && paddr == BVS_ADDR_SCALE) begin
            if (pstrb[1]) s_d.src  = pwdata[BVS_SRC_LSB +: 2];
            if (pstrb[0]) s_d.vsel = pwdata[BVS_VSEL_LSB +: 7];
        end
        if (wr_acc && paddr == BVS_ADDR_BUCK2) begin
            if (pstrb[1]) s_d.rate  = pwdata[BVS_RATE_LSB +: 2];
            if (pstrb[1]) s_d.phase = pwdata[BVS_PHASE_BIT];
            if (pstrb[0]) s_d.flt   = pwdata[BVS_FLT_BIT];
            if (pstrb[0]) s_d.ss    = pwdata[BVS_SS_LSB +: 2];
            // frequency and capacitor bits are read-only to the bus
        end
        // only the configuration store loads these
        if (cfg_load) begin
            s_d.freq = cfg_freq;
            s_d.cap  = cfg_cap;
        end
        s_d.valid = (s_q.freq == 2'h1 || s_q.freq == BVS_FREQ_4MHZ)
                    && s_q.cap == BVS_CAP_OK;

        // scaling source selection
        case (bvs_src_t'(s_q.src))
            BVS_SRC_OFF: s_d.active = 1'b0;
            BVS_SRC_SW:  s_d.active = 1'b1;
            BVS_SRC_HW1: s_d.active = s_q.hw1_sync[1];
            BVS_SRC_HW2: s_d.active = s_q.hw2_sync[1];
            default:     s_d.active = 1'b0;
        endcase

        // clamp code to 0.6..1.8 V range
        if (s_q.vsel <= BVS_VSEL_MIN) begin
            clamped = BVS_VSEL_MIN;
        end else if (s_q.vsel >= BVS_VSEL_MAX) begin
            clamped = BVS_VSEL_MAX;
        end else begin
            clamped = s_q.vsel;
        end

        // step target toward clamped code at the ramp rate; rate 3 loads the clamped code at once
        if (s_q.rate == 2'h3) begin
            s_d.target = clamped;
        end else if (ramp_pulse && s_q.target != clamped) begin
            s_d.ramp_tick = 1'b1;
            if (s_q.target < clamped) s_d.target = s_q.target + 7'h01;
            else                      s_d.target = s_q.target - 7'h01;
        end

        // soft-start: eight current-limit steps
        case (s_q.ss_st)
            BVS_SS_IDLE: begin
                s_d.ss_lvl = 3'h0;
                if (s_q.en_sync[1]) s_d.ss_st = BVS_SS_RUN;
            end
            BVS_SS_RUN: begin
                if (!s_q.en_sync[1]) begin
                    s_d.ss_st = BVS_SS_IDLE;
                end else if (ss_pulse) begin
                    if (s_q.ss_lvl == 3'(BVS_SS_STEPS - 1)) s_d.ss_st = BVS_SS_DONE;
                    else s_d.ss_lvl = s_q.ss_lvl + 3'h1;
                end
            end
            BVS_SS_DONE: begin
                if (!s_q.en_sync[1]) s_d.ss_st = BVS_SS_IDLE;
            end
            default: s_d.ss_st = BVS_SS_IDLE;
        endcase

        s_d.ss_done   = (s_d.ss_st == BVS_SS_DONE);             // registered done flag

        // discharge output when disabled unless floating chosen
        s_d.discharge = !s_q.en_sync[1] && !s_q.flt;
    end

    // ======================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.src    <= BVS_SRC_RST;
            s_q.vsel   <= BVS_VSEL_RST;
            s_q.rate   <= BVS_RATE_RST;
            s_q.phase  <= BVS_PHASE_RST;
            s_q.freq   <= BVS_FREQ_RST;
            s_q.flt    <= BVS_FLT_RST;
            s_q.ss     <= BVS_SS_RST;
            s_q.cap    <= BVS_CAP_RST;
            s_q.ss_st  <= BVS_SS_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign pready                 = s_q.ready;
    assign pslverr                = s_q.err;
    assign prdata                 = s_q.rdata;
    assign buck1_scaling_active   = s_q.active;
    assign buck1_target_code      = s_q.target;
    assign buck2_ramp_tick        = s_q.ramp_tick;
    assign buck2_clock_phase      = s_q.phase;
    assign buck2_switch_frequency = s_q.freq;
    assign buck2_discharge        = s_q.discharge;
    assign buck2_softstart_level  = s_q.ss_lvl;
    assign buck2_softstart_done   = s_q.ss_done;
    assign buck2_config_valid     = s_q.valid;
endmodule

// ==== sim/bvs_ctrl_properties.sv ====
// checker: relations between apb answer and block outputs
// assumes bvs_pkg compiled first; bound to every bvs_ctrl
`timescale 1ns/1ns
module bvs_ctrl_props
    import bvs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        cfg_load,
    input wire logic [6:0]  buck1_target_code,
    input wire logic        buck2_clock_phase,
    input wire logic [1:0]  buck2_switch_frequency,
    input wire logic        buck2_discharge,
    input wire logic        buck2_config_valid
);
    // ======================================================================
    // helpers
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_b2 = pready && !pwrite && paddr == BVS_ADDR_BUCK2;
    wire mapped = paddr inside {BVS_ADDR_SCALE, BVS_ADDR_BUCK2, BVS_ADDR_STAT};
    // ======================================================================
    // properties
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_pready_answer: assert property (ce && psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    a_pready_sel: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_slverr_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_phase_read: assert property (rd_b2 |-> prdata[BVS_PHASE_BIT] == buck2_clock_phase)
        else $error("phase output differs from register");
    a_freq_read: assert property (rd_b2 |-> prdata[9:8] == buck2_switch_frequency)
        else $error("frequency output differs from register");
    a_float_read: assert property (rd_b2 && prdata[BVS_FLT_BIT] |-> !buck2_discharge)
        else $error("discharge while float set");
    a_freq_hold: assert property (!cfg_load [*2] |=> $stable(buck2_switch_frequency))
        else $error("frequency changed without store load");
    a_target_max: assert property (buck1_target_code <= BVS_VSEL_MAX)
        else $error("target code above maximum");
    a_valid_freq: assert property (buck2_config_valid |->
        buck2_switch_frequency inside {2'h1, 2'h2} || $past(buck2_switch_frequency) inside
        {2'h1, 2'h2})
        else $error("config valid with reserved frequency");
endmodule
bind bvs_ctrl bvs_ctrl_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .cfg_load(cfg_load), .buck1_target_code(buck1_target_code),
    .buck2_clock_phase(buck2_clock_phase), .buck2_switch_frequency(buck2_switch_frequency),
    .buck2_discharge(buck2_discharge), .buck2_config_valid(buck2_config_valid));

// ==== sim/buck_voltage_scaling_ctrl_test.sv ====
// bench: bvs_ctrl driven over apb with random and corner stimulus
// assumes bvs_pkg compiled first and the checker bound to bvs_ctrl
`timescale 1ns/1ns
module buck_voltage_scaling_ctrl_test;
    import bvs_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, cfg_load = 0;
    logic hw1 = 0, hw2 = 0, en = 0;
    logic [1:0] cfg_freq = 0, cfg_cap = 0;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic rerr;
    int bad_count = 0, n_compared = 0;
    wire logic pready, pslverr, act_o, tick, phase, disch, ss_done, valid;
    wire logic [31:0] prdata;
    wire logic [6:0] target;
    wire logic [1:0] freq;
    wire logic [2:0] ss_lvl;
    logic [6:0] cor [5] = '{7'h00, 7'h08, 7'h48, 7'h68, 7'h7F};

    bvs_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .cfg_load(cfg_load), .cfg_freq(cfg_freq),
        .cfg_cap(cfg_cap), .hw_scaling_input_one(hw1), .hw_scaling_input_two(hw2),
        .buck2_enable(en), .buck1_scaling_active(act_o), .buck1_target_code(target),
        .buck2_ramp_tick(tick), .buck2_clock_phase(phase), .buck2_switch_frequency(freq),
        .buck2_discharge(disch), .buck2_softstart_level(ss_lvl),
        .buck2_softstart_done(ss_done), .buck2_config_valid(valid));

    // clock
    always #5 pclk = ~pclk;

    // ======================================================================
    // tasks and expectations
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
        chk("apb answer", 32'(n < 16), 1);
    endtask
    task automatic cfg(input logic [1:0] f, input logic [1:0] c);
        cfg_freq <= f;
        cfg_cap <= c;
        cfg_load <= 1;
        @(posedge pclk);
        cfg_load <= 0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic tick_gap(output int g);
        int n;
        for (n = 0; n < 8000 && tick !== 1'b1; n++) @(posedge pclk);
        @(posedge pclk);
        for (g = 1; g < 8000 && tick !== 1'b1; g++) @(posedge pclk);
    endtask
    function automatic logic [6:0] clamp(input logic [6:0] v);
        return v < BVS_VSEL_MIN ? BVS_VSEL_MIN : (v > BVS_VSEL_MAX ? BVS_VSEL_MAX : v);
    endfunction
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog
    initial begin
        #800000;
        bad_count++;
        conclude();
    end

    // ======================================================================
    // main sequence
    initial begin
        int i, g;
        logic [31:0] v;
        void'($urandom(35));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, BVS_ADDR_SCALE, 0);
        chk("scale reset", rdat, 32'h0);
        apb(0, BVS_ADDR_BUCK2, 0);
        chk("buck2 reset", rdat, 32'h9000);
        $display("reset test done");
        apb(1, BVS_ADDR_BUCK2, 32'hD000);
        for (i = 0; i < 13; i++) begin
            v = $urandom & 32'h187F;
            if (i < 5)
                v[6:0] = cor[i];
            if (i == 12)
                v[6:0] = 7'h08;
            apb(1, BVS_ADDR_SCALE, v);
            apb(0, BVS_ADDR_SCALE, 0);
            chk("scale readback", rdat, v);
            for (g = 0; g < 50 && target !== clamp(v[6:0]); g++) @(posedge pclk);
            chk("target code", 32'(target), 32'(clamp(v[6:0])));
        end
        for (i = 0; i < 3; i++) begin
            apb(1, BVS_ADDR_BUCK2, {16'h0, i[1:0], 14'h1000});
            apb(1, BVS_ADDR_SCALE, i[0] ? 32'h08 : 32'h68);
            tick_gap(g);
            chk("ramp interval", 32'(g), 32'(BVS_RAMP_CYC << (2 - i)));
        end
        $display("scaling test done");
        apb(1, BVS_ADDR_SCALE, 32'h40);
        apb(1, BVS_ADDR_BUCK2, 32'h9303);
        apb(0, BVS_ADDR_BUCK2, 0);
        chk("freq cap locked", rdat, 32'h9000);
        for (i = 0; i < 5; i++) begin
            cfg(i[2] ? 2'h1 : i[1:0], i[2] ? 2'h1 : 2'h2);
            chk("config valid", 32'(valid), 32'(i == 1 || i == 2));
        end
        cfg(2'h1, 2'h2);
        apb(0, BVS_ADDR_BUCK2, 0);
        chk("store loaded", rdat, 32'h9102);
        chk("freq out", 32'(freq), 32'h1);
        ce <= 0;
        cfg(2'h2, 2'h2);
        ce <= 1;
        chk("frozen by enable", 32'(freq), 32'h1);
        apb(1, BVS_ADDR_BUCK2, 32'h9080);
        apb(0, BVS_ADDR_BUCK2, 0);
        chk("float readback", rdat, 32'h9182);
        repeat (4) @(posedge pclk);
        chk("float", 32'(disch), 0);
        apb(1, BVS_ADDR_BUCK2, 32'h9000);
        repeat (4) @(posedge pclk);
        chk("discharge", 32'(disch), 1);
        en <= 1;
        for (g = 0; g < 30000 && ss_done !== 1'b1; g++) @(posedge pclk);
        v = BVS_SS_STEPS * BVS_SS_CYC;
        chk("softstart time", 32'(g >= v && g <= v + 8), 1);
        chk("enabled no discharge", 32'(disch), 0);
        chk("softstart level", 32'(ss_lvl), 32'(BVS_SS_STEPS - 1));
        apb(0, BVS_ADDR_STAT, 0);
        chk("status word", rdat & 32'h0077, 32'h0076);
        en <= 0;
        repeat (8) @(posedge pclk);
        chk("softstart idle", 32'(ss_done), 0);
        chk("softstart level idle", 32'(ss_lvl), 0);
        $display("buck2 test done");
        for (i = 0; i < 16; i++) begin
            v = $urandom;
            apb(1, BVS_ADDR_SCALE, {19'h0, i[1:0], 11'h040});
            hw1 <= v[0];
            hw2 <= v[1];
            repeat (8) @(posedge pclk);
            g = i[1] ? (i[0] ? v[1] : v[0]) : i[0];
            chk("scaling active", 32'(act_o), 32'(g));
        end
        apb(1, 18'h00010, 32'hFFFF);
        chk("unmapped error", 32'(rerr), 1);
        apb(0, BVS_ADDR_SCALE, 0);
        chk("unmapped no effect", rdat, 32'h1840);
        $display("source test done");
        conclude();
    end
endmodule
